// [core/io_base_timer_updown.sv]
// Overview of operation
// - Control bits six and five select the counting mode, zero giving increment and one giving up/down.
// - Mode code binary 10 runs the timer as a two-phase pulse decoder on the phase pins.
// - Counting begins once the common start bit or the group start bit is written to one.
// - In up/down mode the timer turns to counting down when it reaches FFFFh.
// - With reset-on-match set, the timer turns down two counts after it equals compare register 0.
// - While counting down the timer turns back up when it reaches 0000h.
// - A low level on the selected external interrupt pin resets the timer when that source is on.
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "base_timer_defs.svh"

module io_base_timer_updown
    import base_timer_pkg::*;
(
    // Clock and reset.
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Register port.
    input  wire reg_req_t    req,
    output logic [15:0]      rdata,
    // Pins.
    input  wire pins_t       pins,
    // Timer state.
    output logic [15:0]      count,
    output logic             counting_down
);

    logic [7:0]  ctrl_r, ctrl_nxt;
    logic        ctrl1_r, ctrl1_nxt;
    logic [15:0] cmp_r, cmp_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    dir_t        dir_r, dir_nxt;
    logic [1:0]  wait_r, wait_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic [3:0]  s1_r, s2_r;
    logic        pa_old_r, pb_old_r;
    logic        down_r, down_nxt;

    // Pins are asynchronous, so each passes two flip-flops before use.
    // The stages reset to the idle pin levels, so no false edge or pin reset follows reset.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            s1_r     <= `SYNC_IDLE;
            s2_r     <= `SYNC_IDLE;
            pa_old_r <= 1'b0;
            pb_old_r <= 1'b0;
        end
        else
        begin
            s1_r     <= {pins.phase_a, pins.phase_b, pins.irq_a_n, pins.irq_b_n};
            s2_r     <= s1_r;
            pa_old_r <= s2_r[3];
            pb_old_r <= s2_r[2];
        end
    end

    logic [1:0] mode;
    logic       started;
    logic       pin_reset;
    logic       pa_edge;

    assign mode      = {ctrl_r[`CTRL_MODE_HI], ctrl_r[`CTRL_MODE_LO]};
    assign started   = ctrl_r[`CTRL_GRP_START] | ctrl_r[`CTRL_COM_START];
    assign pin_reset = ctrl_r[`CTRL_RST_SEL] &
                       (ctrl_r[`CTRL_PIN_SEL] ? ~s2_r[0] : ~s2_r[1]);
    assign pa_edge   = s2_r[3] & ~pa_old_r;

    // Steps wrap silently at the ends; in up/down mode the direction logic turns first.
    function automatic logic [15:0] step_up(input logic [15:0] v);
        return v + 16'h0001;
    endfunction

    function automatic logic [15:0] step_down(input logic [15:0] v);
        return v - 16'h0001;
    endfunction

    always_comb
    begin
        ctrl_nxt  = ctrl_r;
        ctrl1_nxt = ctrl1_r;
        cmp_nxt   = cmp_r;
        cnt_nxt   = cnt_r;
        dir_nxt   = dir_r;
        wait_nxt  = wait_r;
        rdata_nxt = 16'h0000;
        if (req.wr)
        begin
            unique case (req.addr)
                `ADDR_CTRL:     ctrl_nxt  = req.wdata[7:0];
                `ADDR_CTRL1:    ctrl1_nxt = req.wdata[`CTRL1_RST_ON_MATCH];
                `ADDR_COMPARE0: cmp_nxt   = req.wdata;
                default:        ;
            endcase
        end
        if (req.rd)
        begin
            unique case (req.addr)
                `ADDR_CTRL:     rdata_nxt = {8'h00, ctrl_r};
                `ADDR_CTRL1:    rdata_nxt = {15'h0000, ctrl1_r};
                `ADDR_COMPARE0: rdata_nxt = cmp_r;
                `ADDR_COUNT:    rdata_nxt = cnt_r;
                `ADDR_STATUS:   rdata_nxt = {15'h0000, dir_r == DIR_DOWN};
                default:        rdata_nxt = 16'h0000;
            endcase
        end
        if (pin_reset)
        begin
            cnt_nxt  = `COUNT_ZERO;
            dir_nxt  = DIR_UP;
            wait_nxt = 2'h0;
        end
        else if (started)
        begin
            unique case (mode)
                `MODE_INC: cnt_nxt = step_up(cnt_r);
                `MODE_UPDOWN:
                begin
                    unique case (dir_r)
                        DIR_UP:
                        begin
                            cnt_nxt = step_up(cnt_r);
                            if (cnt_nxt == `COUNT_TOP)
                                dir_nxt = DIR_DOWN;
                            else if (ctrl1_r && cnt_r == cmp_r)
                            begin
                                dir_nxt  = DIR_MATCH_WAIT;
                                wait_nxt = `MATCH_DELAY - 2'h1;
                            end
                        end
                        DIR_MATCH_WAIT:
                        begin
                            // The count leaving the match is the first of the delay, so the
                            // turn is taken on the edge that makes the last of them.
                            cnt_nxt  = step_up(cnt_r);
                            wait_nxt = wait_r - 2'h1;
                            if (wait_nxt == 2'h0 || cnt_nxt == `COUNT_TOP)
                                dir_nxt = DIR_DOWN;
                        end
                        DIR_DOWN:
                        begin
                            cnt_nxt = step_down(cnt_r);
                            if (cnt_nxt == `COUNT_ZERO)
                                dir_nxt = DIR_UP;
                        end
                        default: dir_nxt = DIR_UP;
                    endcase
                end
                `MODE_TWOPHASE:
                begin
                    // Phase B level at the A edge gives direction, as a quadrature decoder.
                    if (pa_edge)
                        cnt_nxt = pb_old_r ? step_down(cnt_r) : step_up(cnt_r);
                end
                default: ;
            endcase
        end
        // Registered so the direction output flips on the same edge as the count.
        down_nxt = (dir_nxt == DIR_DOWN);
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_r  <= `CTRL_RESET;
            ctrl1_r <= 1'b0;
            cmp_r   <= `COUNT_ZERO;
            cnt_r   <= `COUNT_ZERO;
            dir_r   <= DIR_UP;
            wait_r  <= 2'h0;
            rdata_r <= 16'h0000;
            down_r  <= 1'b0;
        end
        else
        begin
            ctrl_r  <= ctrl_nxt;
            ctrl1_r <= ctrl1_nxt;
            cmp_r   <= cmp_nxt;
            cnt_r   <= cnt_nxt;
            dir_r   <= dir_nxt;
            wait_r  <= wait_nxt;
            rdata_r <= rdata_nxt;
            down_r  <= down_nxt;
        end
    end

    assign rdata         = rdata_r;
    assign count         = cnt_r;
    assign counting_down = down_r;

    a_inc_step: assert property (@(posedge ref_clk) disable iff (rst)
        (started && mode == `MODE_INC && !pin_reset) |=> cnt_r == $past(cnt_r) + 16'h0001)
        else $error("Increment mode did not step by one.");
    a_top_turn: assert property (@(posedge ref_clk) disable iff (rst)
        (started && mode == `MODE_UPDOWN && !pin_reset && cnt_r == 16'hFFFE
         && dir_r != DIR_DOWN) |=> dir_r == DIR_DOWN)
        else $error("No turn down at top.");
    a_zero_turn: assert property (@(posedge ref_clk) disable iff (rst)
        (started && mode == `MODE_UPDOWN && !pin_reset && dir_r == DIR_DOWN
         && cnt_r == 16'h0001) |=> dir_r == DIR_UP && cnt_r == 16'h0000)
        else $error("No turn up at zero.");
    sequence match_seen;
        started && mode == `MODE_UPDOWN && ctrl1_r && dir_r == DIR_UP
        && cnt_r == cmp_r && cnt_r < 16'hFFF0 && !pin_reset;
    endsequence
    sequence match_hold;
        started && !pin_reset && mode == `MODE_UPDOWN;
    endsequence
    a_match_wait: assert property (@(posedge ref_clk) disable iff (rst)
        match_seen |=> dir_r == DIR_MATCH_WAIT)
        else $error("Match did not keep the count rising.");
    a_match_turn: assert property (@(posedge ref_clk) disable iff (rst)
        match_seen ##1 match_hold |=> dir_r == DIR_DOWN && cnt_r == $past(cnt_r) + 16'h0001)
        else $error("No turn down two counts after match.");
    a_pin_reset: assert property (@(posedge ref_clk) disable iff (rst)
        pin_reset |=> cnt_r == 16'h0000)
        else $error("Pin reset did not clear the count.");
    a_start_gate: assert property (@(posedge ref_clk) disable iff (rst)
        (!started && !pin_reset) |=> $stable(cnt_r))
        else $error("Count moved while stopped.");
    a_down_step: assert property (@(posedge ref_clk) disable iff (rst)
        (started && mode == `MODE_UPDOWN && dir_r == DIR_DOWN && !pin_reset)
        |=> cnt_r == $past(cnt_r) - 16'h0001)
        else $error("Down step wrong.");
    a_twophase: assert property (@(posedge ref_clk) disable iff (rst)
        (started && mode == `MODE_TWOPHASE && !pa_edge && !pin_reset) |=> $stable(cnt_r))
        else $error("Two-phase count moved without an edge.");

endmodule // io_base_timer_updown

// [pkg/base_timer_defs.svh]
`ifndef BASE_TIMER_DEFS_SVH
`define BASE_TIMER_DEFS_SVH

// Register indices on the plain register port.
`define ADDR_CTRL      4'h0
`define ADDR_CTRL1     4'h1
`define ADDR_COMPARE0  4'h2
`define ADDR_COUNT     4'h3
`define ADDR_STATUS    4'h4

// Field positions in the control register.
`define CTRL_MODE_LO   5
`define CTRL_MODE_HI   6
`define CTRL_GRP_START 0
`define CTRL_COM_START 1
`define CTRL_RST_SEL   2
`define CTRL_PIN_SEL   3

// Field positions in control register 1.
`define CTRL1_RST_ON_MATCH 0

// Counting mode codes.
`define MODE_INC       2'h0
`define MODE_UPDOWN    2'h1
`define MODE_TWOPHASE  2'h2

// Count limits and reset values.
`define COUNT_TOP      16'hFFFF
`define COUNT_ZERO     16'h0000
`define CTRL_RESET     8'h00
`define MATCH_DELAY    2'h2
`define SYNC_IDLE      4'h3

`endif

// [pkg/base_timer_pkg.sv]
package base_timer_pkg;

    typedef enum logic [1:0] {DIR_UP, DIR_MATCH_WAIT, DIR_DOWN} dir_t;

    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    typedef struct packed {
        logic phase_a;
        logic phase_b;
        logic irq_a_n;
        logic irq_b_n;
    } pins_t;

endpackage

// [test/io_base_timer_updown_tb_top.sv]
`timescale 1ns/1ps
`include "base_timer_defs.svh"

module io_base_timer_updown_tb_top;
    import base_timer_pkg::*;

    logic        ref_clk     = 1'b0;
    logic        rst         = 1'b1;
    reg_req_t    req         = '0;
    pins_t       pins        = 4'b0011;
    logic [15:0] rdata;
    logic [15:0] count;
    logic        counting_down;
    int          failures    = 0;
    int          check_count = 0;
    int          bad;
    int          n;
    logic [15:0] pk;
    logic [15:0] c;
    logic [15:0] e;
    logic        ph;

    io_base_timer_updown dut_u (
        .ref_clk       (ref_clk),
        .rst           (rst),
        .req           (req),
        .rdata         (rdata),
        .pins          (pins),
        .count         (count),
        .counting_down (counting_down)
    );

    always #25 ref_clk = ~ref_clk;

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk);
        req.wr <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        req <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge ref_clk);
        req.rd <= 1'b0;
        #1 chk("rdata", rdata, exp);
    endtask

    // Stops the timer, then clears it through the selected pin.
    task automatic zero(input logic sel);
        wr(`ADDR_CTRL, {12'h000, sel, 3'b100});
        if (sel)
            pins.irq_b_n <= 1'b0;
        else
            pins.irq_a_n <= 1'b0;
        repeat (5) @(posedge ref_clk);
        #1 chk("pin reset", count, `COUNT_ZERO);
        @(posedge ref_clk);
        pins.irq_a_n <= 1'b1;
        pins.irq_b_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        #1 chk("stopped", count, `COUNT_ZERO);
        rd(`ADDR_COUNT, `COUNT_ZERO);
        rd(`ADDR_STATUS, 16'h0000);
    endtask

    // Every step must be one count, and a fall must follow a down flag.
    // A wrap across zero or the top shows as a huge step, so it is caught too.
    task automatic trace(input int cycles);
        logic [15:0] p;
        logic        pd;
        int          d;
        @(posedge ref_clk);
        #1 p = count;
        pd = counting_down;
        pk = count;
        c = count;
        bad = 0;
        repeat (cycles)
        begin
            @(posedge ref_clk);
            #1 d = int'(count) - int'(p);
            if ((d != 1 && d != -1) || (d == -1 && !pd) || (d == 1 && pd))
                bad++;
            if (count > pk)
                pk = count;
            p = count;
            pd = counting_down;
        end
    endtask

    initial
    begin
        void'($urandom(32'h8956));
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        #1 chk("reset count", count, `COUNT_ZERO);
        rd(4'hF, 16'h0000);
        for (int s = 1; s <= 2; s++)
        begin
            n = 20 + $urandom % 50;
            zero(s == 2);
            wr(`ADDR_CTRL, 16'(s));
            trace(n);
            chk("inc rise", pk - c, 16'(n));
            chk("inc steps", 16'(bad), 16'h0000);
        end
        e = 16'(3 + $urandom % 40);
        zero(1'b0);
        wr(`ADDR_COMPARE0, e);
        wr(`ADDR_CTRL1, 16'h0001);
        wr(`ADDR_CTRL, 16'h0021);
        trace(2 * e + 16);
        chk("match peak", pk, e + 16'h0002);
        chk("updown steps", 16'(bad), 16'h0000);
        rd(`ADDR_COMPARE0, e);
        rd(`ADDR_CTRL, 16'h0021);
        zero(1'b1);
        wr(`ADDR_CTRL1, 16'h0000);
        wr(`ADDR_CTRL, 16'h0022);
        trace(65545);
        chk("top peak", pk, `COUNT_TOP);
        chk("top steps", 16'(bad), 16'h0000);
        zero(1'b0);
        wr(`ADDR_CTRL, 16'h0041);
        e = `COUNT_ZERO;
        repeat (12)
        begin
            ph = 1'($urandom % 2);
            @(posedge ref_clk);
            pins.phase_b <= ph;
            repeat (2) @(posedge ref_clk);
            pins.phase_a <= 1'b1;
            repeat (6) @(posedge ref_clk);
            pins.phase_a <= 1'b0;
            e = ph ? e - 16'h0001 : e + 16'h0001;
            repeat (6) @(posedge ref_clk);
            #1 chk("two-phase count", count, e);
        end
        end_sim;
    end

    initial
    begin
        repeat (80000) @(posedge ref_clk);
        failures++;
        end_sim;
    end

endmodule // io_base_timer_updown_tb_top
